// >>> hw/bfle_defines.svh
// constants for the bit, flag and indirect load execution block
`ifndef BFLE_DEFINES_SVH
`define BFLE_DEFINES_SVH

// flag positions in the flag status word
`define BFLE_FLAG_C     3'd0
`define BFLE_FLAG_Z     3'd1
`define BFLE_FLAG_N     3'd2
`define BFLE_FLAG_V     3'd3
`define BFLE_FLAG_S     3'd4
`define BFLE_FLAG_H     3'd5
`define BFLE_FLAG_T     3'd6
`define BFLE_FLAG_I     3'd7

// cycle counts
`define BFLE_SINGLE_CYCLES 1
`define BFLE_LOAD_CYCLES   2

// reset values
`define BFLE_FLAGS_RESET 8'h00
`define BFLE_DATA_RESET  8'h00

`endif

// >>> hw/bfle_exec.sv
// execution of shifts, bit transfer, flag ops and indirect loads
//
// How it works
// [RULE1] rotate right via carry: old carry to bit 7, bit 0 to carry, 1 cycle
// [RULE2] copy bit to flag: selected source bit into T, nothing else, 1 cycle
// [RULE3] copy flag to bit: T into selected destination bit, flags kept, 1 cycle
// [RULE4] half carry set and clear force H only, 1 cycle each
// [RULE5] sign flag set and clear force S only, 1 cycle each
// [RULE6] overflow set and clear force V only, 1 cycle each
// [RULE7] post-increment load reads at pointer, then pointer plus one, 2 cycles
// [RULE8] pre-decrement load: pointer minus one, then reads there, 2 cycles
// [RULE9] offset load reads at Y or Z plus displacement, pointer kept, 2 cycles
// [RULE10] signed shift right keeps bit 7, bit 0 to carry, 1 cycle
// [RULE11] nibble swap exchanges halves, flags unchanged, 1 cycle
`timescale 1ns/1ps
`include "bfle_defines.svh"

module bfle_exec #(
    parameter int ADDR_WIDTH = 16,
    parameter int DISP_WIDTH = 6
) (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_op_valid,
    input  wire bfle_pkg::bfle_op_type i_op,
    input  wire logic [2:0]            i_bit_sel,
    input  wire bfle_pkg::bfle_ptr_type i_ptr_sel,
    input  wire logic [DISP_WIDTH-1:0] i_disp,
    input  wire logic [7:0]            i_operand,
    input  wire logic [ADDR_WIDTH-1:0] i_ptr_value,
    input  wire logic [7:0]            i_flags,
    input  wire logic [7:0]            i_mem_rdata,
    output logic                       o_busy,
    output logic                       o_done,
    output logic                       o_reg_we,
    output logic [7:0]                 o_reg_wdata,
    output logic                       o_flags_we,
    output logic [7:0]                 o_flags,
    output logic                       o_ptr_we,
    output bfle_pkg::bfle_ptr_type     o_ptr_sel,
    output logic [ADDR_WIDTH-1:0]      o_ptr_wdata,
    output logic                       o_mem_re,
    output logic [ADDR_WIDTH-1:0]      o_mem_addr
);

    initial begin
        if (ADDR_WIDTH < 8 || ADDR_WIDTH > 16 || DISP_WIDTH < 1 ||
            DISP_WIDTH > ADDR_WIDTH) begin
            $error("bfle_exec: unsupported width parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // combinational next values

    bfle_pkg::bfle_state_type state;
    bfle_pkg::bfle_state_type next_state;
    logic                     next_done;
    logic                     next_reg_we;
    logic [7:0]               next_reg_wdata;
    logic                     next_flags_we;
    logic [7:0]               next_flags;
    logic                     next_ptr_we;
    bfle_pkg::bfle_ptr_type   next_ptr_sel;
    logic [ADDR_WIDTH-1:0]    next_ptr_wdata;
    logic                     next_mem_re;
    logic [ADDR_WIDTH-1:0]    next_mem_addr;
    logic                     load_start;

    assign load_start = i_op_valid && state == bfle_pkg::BFLE_ST_IDLE &&
                        (i_op == bfle_pkg::BFLE_OP_LOAD_PLAIN ||
                         i_op == bfle_pkg::BFLE_OP_LOAD_INC ||
                         i_op == bfle_pkg::BFLE_OP_LOAD_DEC ||
                         i_op == bfle_pkg::BFLE_OP_LOAD_DISP);

    always_comb begin
        logic [7:0] res;
        logic [7:0] fl;
        res            = i_operand;
        fl             = i_flags;
        next_state     = state;
        next_done      = 1'b0;
        next_reg_we    = 1'b0;
        next_reg_wdata = o_reg_wdata;
        next_flags_we  = 1'b0;
        next_flags     = o_flags;
        next_ptr_we    = 1'b0;
        next_ptr_sel   = o_ptr_sel;
        next_ptr_wdata = o_ptr_wdata;
        next_mem_re    = 1'b0;
        next_mem_addr  = o_mem_addr;
        case (state)
            bfle_pkg::BFLE_ST_IDLE: begin
                if (i_op_valid) begin
                    case (i_op)
                        bfle_pkg::BFLE_OP_ROR_CARRY: begin
                            res = {i_flags[`BFLE_FLAG_C], i_operand[7:1]}; // see [RULE1]
                            fl[`BFLE_FLAG_C] = i_operand[0];
                        end
                        bfle_pkg::BFLE_OP_SHIFT_SIGN: begin
                            res = {i_operand[7], i_operand[7:1]}; // see [RULE10]
                            fl[`BFLE_FLAG_C] = i_operand[0];
                        end
                        bfle_pkg::BFLE_OP_SWAP: begin
                            res = {i_operand[3:0], i_operand[7:4]}; // see [RULE11]
                        end
                        bfle_pkg::BFLE_OP_BIT_TO_T: begin
                            fl[`BFLE_FLAG_T] = i_operand[i_bit_sel]; // see [RULE2]
                        end
                        bfle_pkg::BFLE_OP_T_TO_BIT: begin
                            res[i_bit_sel] = i_flags[`BFLE_FLAG_T]; // see [RULE3]
                        end
                        bfle_pkg::BFLE_OP_FLAG_SET: begin
                            fl[i_bit_sel] = 1'b1; // see [RULE4] [RULE5] [RULE6]
                        end
                        bfle_pkg::BFLE_OP_FLAG_CLEAR: begin
                            fl[i_bit_sel] = 1'b0; // see [RULE4] [RULE5] [RULE6]
                        end
                        default: begin
                        end
                    endcase
                    // shifts derive z, n, v and s from the result
                    if (i_op == bfle_pkg::BFLE_OP_ROR_CARRY ||
                        i_op == bfle_pkg::BFLE_OP_SHIFT_SIGN) begin
                        fl[`BFLE_FLAG_Z] = (res == 8'h00); // see [RULE1] [RULE10]
                        fl[`BFLE_FLAG_N] = res[7];
                        fl[`BFLE_FLAG_V] = res[7] ^ fl[`BFLE_FLAG_C];
                        fl[`BFLE_FLAG_S] = res[7] ^ fl[`BFLE_FLAG_V];
                    end
                    if (load_start) begin
                        next_state   = bfle_pkg::BFLE_ST_LOAD;
                        next_mem_re  = 1'b1;
                        next_ptr_sel = i_ptr_sel;
                        case (i_op)
                            bfle_pkg::BFLE_OP_LOAD_INC: begin
                                next_mem_addr  = i_ptr_value; // see [RULE7]
                                next_ptr_wdata = i_ptr_value +
                                                 ADDR_WIDTH'(1);
                                next_ptr_we    = 1'b1;
                            end
                            bfle_pkg::BFLE_OP_LOAD_DEC: begin
                                next_mem_addr  = i_ptr_value -
                                                 ADDR_WIDTH'(1); // see [RULE8]
                                next_ptr_wdata = next_mem_addr;
                                next_ptr_we    = 1'b1;
                            end
                            bfle_pkg::BFLE_OP_LOAD_DISP: begin
                                next_mem_addr = i_ptr_value + // see [RULE9]
                                    ADDR_WIDTH'(i_disp);
                            end
                            default: begin
                                next_mem_addr = i_ptr_value;
                            end
                        endcase
                    end else begin
                        next_done      = 1'b1;
                        next_reg_we    = (res != i_operand) ||
                            i_op == bfle_pkg::BFLE_OP_ROR_CARRY ||
                            i_op == bfle_pkg::BFLE_OP_SHIFT_SIGN ||
                            i_op == bfle_pkg::BFLE_OP_SWAP ||
                            i_op == bfle_pkg::BFLE_OP_T_TO_BIT;
                        next_reg_wdata = res;
                        next_flags_we  = i_op != bfle_pkg::BFLE_OP_SWAP &&
                            i_op != bfle_pkg::BFLE_OP_T_TO_BIT &&
                            i_op != bfle_pkg::BFLE_OP_NONE;
                        next_flags     = fl;
                    end
                end
            end
            bfle_pkg::BFLE_ST_LOAD: begin
                // second cycle: memory data lands, no flags touched
                next_state     = bfle_pkg::BFLE_ST_IDLE;
                next_done      = 1'b1;
                next_reg_we    = 1'b1; // see [RULE7] [RULE8] [RULE9]
                next_reg_wdata = i_mem_rdata;
            end
            default: begin
                next_state = bfle_pkg::BFLE_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state       <= bfle_pkg::BFLE_ST_IDLE;
            o_done      <= 1'b0;
            o_reg_we    <= 1'b0;
            o_reg_wdata <= `BFLE_DATA_RESET;
            o_flags_we  <= 1'b0;
            o_flags     <= `BFLE_FLAGS_RESET;
            o_ptr_we    <= 1'b0;
            o_ptr_sel   <= bfle_pkg::BFLE_PTR_X;
            o_ptr_wdata <= '0;
            o_mem_re    <= 1'b0;
            o_mem_addr  <= '0;
        end else begin
            state       <= next_state;
            o_done      <= next_done;
            o_reg_we    <= next_reg_we;
            o_reg_wdata <= next_reg_wdata;
            o_flags_we  <= next_flags_we;
            o_flags     <= next_flags;
            o_ptr_we    <= next_ptr_we;
            o_ptr_sel   <= next_ptr_sel;
            o_ptr_wdata <= next_ptr_wdata;
            o_mem_re    <= next_mem_re;
            o_mem_addr  <= next_mem_addr;
        end
    end

    assign o_busy = (state != bfle_pkg::BFLE_ST_IDLE);

endmodule : bfle_exec

// >>> hw/bfle_pkg.sv
// types for the bit, flag and indirect load execution block
package bfle_pkg;

    typedef enum logic [3:0] {
        BFLE_OP_NONE       = 4'h0,
        BFLE_OP_ROR_CARRY  = 4'h1,
        BFLE_OP_SHIFT_SIGN = 4'h2,
        BFLE_OP_SWAP       = 4'h3,
        BFLE_OP_BIT_TO_T   = 4'h4,
        BFLE_OP_T_TO_BIT   = 4'h5,
        BFLE_OP_FLAG_SET   = 4'h6,
        BFLE_OP_FLAG_CLEAR = 4'h7,
        BFLE_OP_LOAD_PLAIN = 4'h8,
        BFLE_OP_LOAD_INC   = 4'h9,
        BFLE_OP_LOAD_DEC   = 4'ha,
        BFLE_OP_LOAD_DISP  = 4'hb
    } bfle_op_type;

    typedef enum logic [1:0] {
        BFLE_PTR_X = 2'h0,
        BFLE_PTR_Y = 2'h1,
        BFLE_PTR_Z = 2'h2
    } bfle_ptr_type;

    // gray coded: idle -> wait for memory -> idle
    typedef enum logic [1:0] {
        BFLE_ST_IDLE = 2'b00,
        BFLE_ST_LOAD = 2'b01
    } bfle_state_type;

endpackage : bfle_pkg

// >>> verif/bfle_exec_props.sv
// property checker for the bit, flag and load execution block
`timescale 1ns/1ps
module bfle_exec_props #(
    parameter int ADDR_WIDTH = 16,
    parameter int DISP_WIDTH = 6
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_reset_n,
    input wire logic                  i_op_valid,
    input wire bfle_pkg::bfle_op_type i_op,
    input wire logic [2:0]            i_bit_sel,
    input wire logic [DISP_WIDTH-1:0] i_disp,
    input wire logic [7:0]            i_operand,
    input wire logic [ADDR_WIDTH-1:0] i_ptr_value,
    input wire logic [7:0]            i_flags,
    input wire logic [7:0]            i_mem_rdata,
    input wire logic                  o_busy,
    input wire logic                  o_done,
    input wire logic                  o_reg_we,
    input wire logic [7:0]            o_reg_wdata,
    input wire logic                  o_flags_we,
    input wire logic [7:0]            o_flags,
    input wire logic                  o_ptr_we,
    input wire logic [ADDR_WIDTH-1:0] o_ptr_wdata,
    input wire logic                  o_mem_re,
    input wire logic [ADDR_WIDTH-1:0] o_mem_addr
);
    logic                  take_q;
    logic [3:0]            op_q;
    logic [7:0]            opnd_q;
    logic [7:0]            flg_q;
    logic [2:0]            sel_q;
    logic [ADDR_WIDTH-1:0] ptr_q;
    logic [DISP_WIDTH-1:0] disp_q;
    logic [15:0]           hit;
    logic [7:0]            msk;
    // one-hot of the op taken at the last edge, indexed by op code
    assign hit = take_q ? 16'h0001 << op_q : 16'h0000;
    assign msk = 8'h01 << sel_q;
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            take_q <= 1'b0;
        end else begin
            take_q <= i_op_valid && !o_busy;
        end
    end
    always_ff @(posedge i_core_clk) begin
        {op_q, opnd_q, flg_q} <= {i_op, i_operand, i_flags};
        {sel_q, ptr_q, disp_q} <= {i_bit_sel, i_ptr_value, i_disp};
    end
    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);
    ror_result_a: assert property (
        hit[1] |-> o_done && o_flags_we && o_flags[0] == opnd_q[0] &&
        o_reg_wdata == {flg_q[0], opnd_q[7:1]}) else $error("rotate");
    sign_shift_a: assert property (
        hit[2] |-> o_done && o_reg_wdata == {opnd_q[7], opnd_q[7:1]} &&
        o_flags[0] == opnd_q[0]) else $error("signed shift");
    nibble_swap_a: assert property (
        hit[3] |-> o_reg_we && !o_flags_we &&
        o_reg_wdata == {opnd_q[3:0], opnd_q[7:4]}) else $error("swap");
    bit_to_flag_a: assert property (
        hit[4] |-> o_flags_we && o_done &&
        o_flags == {flg_q[7], opnd_q[sel_q], flg_q[5:0]}) else $error("to t");
    flag_to_bit_a: assert property (
        hit[5] |-> o_reg_we && !o_flags_we && o_reg_wdata[sel_q] == flg_q[6]
        && ((o_reg_wdata ^ opnd_q) & ~msk) == 8'h00) else $error("to bit");
    flag_force_a: assert property (
        hit[6] || hit[7] |-> o_flags_we && o_done &&
        o_flags == (hit[6] ? flg_q | msk : flg_q & ~msk)) else $error("flag");
    post_inc_a: assert property (
        hit[9] |-> o_mem_re && o_mem_addr == ptr_q && o_ptr_we &&
        o_ptr_wdata == ptr_q + 1'b1 ##1 o_done) else $error("post inc");
    pre_dec_a: assert property (
        hit[10] |-> o_mem_re && o_ptr_we && o_mem_addr == ptr_q - 1'b1 &&
        o_ptr_wdata == o_mem_addr ##1 o_done) else $error("pre dec");
    disp_load_a: assert property (
        hit[11] |-> o_mem_re && !o_ptr_we && o_mem_addr == ptr_q + disp_q
        ##1 o_done) else $error("displacement load");
    load_data_a: assert property (
        o_mem_re |-> o_busy ##1 o_reg_we && !o_flags_we &&
        o_reg_wdata == $past(i_mem_rdata)) else $error("load data");
    cover property (hit[9]);
    cover property (hit[11]);
    cover property (hit[7]);
endmodule : bfle_exec_props

// >>> verif/bfle_mem_model.sv
// data memory partner answering reads in the same cycle
`timescale 1ns/1ps
module bfle_mem_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_mem_re,
    input  wire logic [15:0] i_mem_addr,
    output logic [7:0]       o_mem_rdata
);
    logic [7:0] junk = 8'h00;
    // bus churns between reads so stale data never looks valid
    always_ff @(posedge i_core_clk) begin
        junk <= junk + 8'h3b;
    end
    assign o_mem_rdata = i_mem_re ? i_mem_addr[7:0] ^ 8'ha5 : junk;
endmodule : bfle_mem_model

// >>> verif/tb_top.sv
// self-checking bench for the bit, flag and load execution block
`timescale 1ns/1ps
module tb_top;
    logic                  clk;
    logic                  rst_n;
    logic                  valid;
    bfle_pkg::bfle_op_type op;
    logic [2:0]            sel;
    logic [7:0]            opnd;
    logic [7:0]            flg;
    logic [7:0]            rdata;
    logic                  busy, done, reg_we, flags_we, ptr_we, mem_re;
    logic [7:0]            reg_wdata, flags;
    logic [15:0]           ptr_wdata, mem_addr;
    bfle_pkg::bfle_ptr_type psel;
    int                    failures;
    int                    samples_checked;
    bfle_exec i_dut (
        .i_core_clk(clk), .i_reset_n(rst_n), .i_op_valid(valid), .i_op(op),
        .i_bit_sel(sel), .i_ptr_sel(bfle_pkg::bfle_ptr_type'(sel[1:0])),
        .i_disp(6'h3f), .i_operand(opnd), .i_ptr_value(16'h1234),
        .i_flags(flg), .i_mem_rdata(rdata), .o_busy(busy), .o_done(done),
        .o_reg_we(reg_we), .o_reg_wdata(reg_wdata), .o_flags_we(flags_we),
        .o_flags(flags), .o_ptr_we(ptr_we), .o_ptr_sel(psel),
        .o_ptr_wdata(ptr_wdata), .o_mem_re(mem_re), .o_mem_addr(mem_addr));
    bfle_mem_model i_mem (.i_core_clk(clk), .i_mem_re(mem_re),
        .i_mem_addr(mem_addr), .o_mem_rdata(rdata));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [23:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic issue(input bfle_pkg::bfle_op_type o,
                         input logic [7:0] d, f, input logic [2:0] s);
        @(posedge clk);
        valid <= 1'b1;
        op <= o;
        {opnd, flg, sel} <= {d, f, s};
        @(posedge clk);
        valid <= 1'b0;
        #1;
    endtask : issue
    task automatic t_shifts;
        issue(bfle_pkg::BFLE_OP_ROR_CARRY, 8'h01, 8'h01, 3'h0);
        chk("rotate", {done, flags[3:0], reg_wdata}, 24'h1580);
        issue(bfle_pkg::BFLE_OP_SHIFT_SIGN, 8'h82, 8'h00, 3'h0);
        chk("sign shift", {flags[3:0], reg_wdata}, 24'hcc1);
        issue(bfle_pkg::BFLE_OP_SWAP, 8'h3c, 8'h00, 3'h0);
        chk("swap", {flags_we, reg_wdata}, 24'h0c3);
    endtask : t_shifts
    task automatic t_bits;
        issue(bfle_pkg::BFLE_OP_BIT_TO_T, 8'h20, 8'h81, 3'h5);
        chk("to flag", {flags_we, flags}, 24'h1c1);
        issue(bfle_pkg::BFLE_OP_T_TO_BIT, 8'h00, 8'h40, 3'h7);
        chk("to bit", {flags_we, reg_wdata}, 24'h080);
    endtask : t_bits
    task automatic t_flags;
        for (int k = 3; k < 6; k++) begin
            issue(bfle_pkg::BFLE_OP_FLAG_SET, 8'h00, 8'h00, 3'(k));
            chk("set", {flags_we, flags},
                24'h100 | (24'h1 << k));
            issue(bfle_pkg::BFLE_OP_FLAG_CLEAR, 8'h00, 8'hff, 3'(k));
            chk("clear", {flags_we, flags},
                24'h1ff & ~(24'h1 << k));
        end
    endtask : t_flags
    task automatic ld(input bfle_pkg::bfle_op_type o, input logic [2:0] s,
                      input logic [15:0] a, input logic pw, input logic [15:0] p);
        issue(o, 8'h00, 8'h00, s);
        chk("load address", {busy, mem_re, ptr_we, mem_addr},
            {2'b11, pw, a});
        chk("pointer select", psel, s[1:0]);
        if (pw) begin
            chk("pointer", ptr_wdata, p);
        end
        @(posedge clk);
        #1;
        chk("load data", {done, reg_we, flags_we, reg_wdata},
            {3'b110, a[7:0] ^ 8'ha5});
    endtask : ld
    task automatic t_loads;
        ld(bfle_pkg::BFLE_OP_LOAD_INC, 3'h0, 16'h1234, 1'b1,
           16'h1235);
        ld(bfle_pkg::BFLE_OP_LOAD_DEC, 3'h1, 16'h1233, 1'b1,
           16'h1233);
        ld(bfle_pkg::BFLE_OP_LOAD_DISP, 3'h2, 16'h1273, 1'b0,
           16'h0);
    endtask : t_loads
    task automatic end_sim;
        if (failures == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {failures, samples_checked} = '0;
        {rst_n, valid, sel, opnd, flg} = '0;
        op = bfle_pkg::BFLE_OP_NONE;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_shifts();
        t_bits();
        t_flags();
        t_loads();
        end_sim();
    end
    initial begin
        #50000;
        failures++;
        end_sim();
    end
endmodule : tb_top

bind bfle_exec bfle_exec_props #(
    .ADDR_WIDTH(ADDR_WIDTH),
    .DISP_WIDTH(DISP_WIDTH)
) i_props (.*);
